// ==== shared/omt_defines.vh ====
// Constants for the offline motor tuning sequencer: register offsets,
// field positions, status codes and timing figures.
// Assumes inclusion by bare name from the design files.
`ifndef OMT_DEFINES_VH
`define OMT_DEFINES_VH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OMT_REG_CTRL      12'h000
`define OMT_REG_CONFIG    12'h004
`define OMT_REG_STATUS    12'h008
`define OMT_REG_MEAS_IN   12'h00C
`define OMT_REG_CONST0    12'h010
`define OMT_REG_MONITOR   12'h030
// ****************************************************************
// Field positions and values
// ****************************************************************
`define OMT_SENTINEL      16'h270F
`define OMT_MODE_NONE     8'h00
`define OMT_MODE_ALL      8'h01
`define OMT_MODE_R1       8'h0B
`define OMT_ST_RUN_ALL    8'h02
`define OMT_ST_RUN_R1     8'h0C
`define OMT_ST_DONE_ALL   8'h03
`define OMT_ST_DONE_R1    8'h0D
`define OMT_ERR_FORCED    8'h08
`define OMT_ERR_TRIP      8'h09
`define OMT_ERR_STALL     8'h5B
`define OMT_ERR_DCBUS     8'h5C
`define OMT_ERR_CALC      8'h5D
`define OMT_CTRL_VECTOR   0
`define OMT_CTRL_DR_RESET 1
`define OMT_NUM_CONST     7
// ****************************************************************
// Timing
// ****************************************************************
`define OMT_CLK_MHZ       125
`define OMT_T_ALL_S       25
`define OMT_T_R1_S        9
`define OMT_CYC_ALL       (`OMT_T_ALL_S * `OMT_CLK_MHZ * 1000000)
`define OMT_CYC_R1        (`OMT_T_R1_S * `OMT_CLK_MHZ * 1000000)
`endif

// ==== core/omt_sequencer.v ====
// Offline motor tuning sequencer: start, abort, status codes, progress
// output and retention of the measured motor constants, with APB access.
// Assumes start/stop inputs already synchronous to pclk and debounced.
//
// Overview of operation
// - Tune only with capacity and pole count not 9999 and vector control chosen.
// - Mode 1 measures all constants without rotation, about 25 to 75 s.
// - Mode 11 measures primary resistance only, about 9 s.
// - Start on run key, direction key, or forward/reverse start input rising; the code has no direction key input.
// - Abort on output stop, reset input, stop key or start released.
// - While tuning only listed inputs act; only run, monitor, fault and tuning_active outputs driven.
// - Progress shown in eight steps on monitor when it selects speed/frequency.
// - Running output asserts as soon as tuning starts.
// - Status goes 1/11 to 2/12 while tuning, then 3/13 on normal end.
// - Set frequency monitor reads zero while tuning.
// - Stop or start release after end clears state; new run refused before.
// - Changing mode after 3/13 marks stored tuning data invalid.
// - Error end leaves constants unset; drive reset needed before retuning.
// - Error codes 8, 9, 91, 92, 93 by cause.
// - Stop key or start release abort stores no constants.
// - Measured constants kept until another tuning run completes.
// - Power loss during tuning gives error; then normal operation resumes.
// - Tuning also allowed under V/F via the control switch input.
// - Mode 0 performs no tuning.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "omt_defines.vh"
`default_nettype none
module omt_sequencer #(
   parameter [31:0] CYC_ALL = `OMT_CYC_ALL,
   parameter [31:0] CYC_R1  = `OMT_CYC_R1
) (
   // Clock and reset.
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Operator and terminal inputs.
   input  wire        run_key,
   input  wire        stop_key,
   input  wire        forward_start_input,
   input  wire        reverse_start_input,
   input  wire        output_stop_input,
   input  wire        reset_input,
   input  wire        vf_switch_input,
   input  wire        power_loss,
   // Measurement engine events.
   input  wire        meas_stall,
   input  wire        meas_dcbus,
   input  wire        meas_calc_err,
   input  wire        prot_trip,
   // Outputs.
   output reg         running_output,
   output reg  [2:0]  analogue_monitor_output,
   output reg         fault_relay,
   output reg         normal_run,
   output reg         tuning_active
);
   // ****************************************************************
   // States
   // ****************************************************************
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_TUNE = 2'd1;
   localparam [1:0] ST_DONE = 2'd2;
   localparam [1:0] ST_ERR  = 2'd3;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [1:0]  state;
   reg  [7:0]  tuning_mode_and_status;
   reg  [15:0] motor_capacity_setting;
   reg  [15:0] motor_pole_count;
   reg         vector_sel;
   reg         monitor_sel_speed;
   reg         drive_reset_done;
   reg         data_valid;
   reg         power_err;
   reg         mode_was_all;
   reg         start_was_terminal;
   reg  [31:0] tick;
   reg  [15:0] meas_in;
   reg  [15:0] consts [0:`OMT_NUM_CONST-1];
   reg         fwd_d;
   reg         rev_d;
   reg         run_d;
   reg  [15:0] set_freq;

   wire acc   = psel & penable;
   wire wr    = acc & pwrite;
   wire start_edge = (forward_start_input & ~fwd_d) | (reverse_start_input & ~rev_d)
                   | (run_key & ~run_d);
   wire start_held = forward_start_input | reverse_start_input;
   // Tuning allowed only with set constants and a vector method, or V/F switch.
   wire allowed = (motor_capacity_setting != `OMT_SENTINEL)
                & (motor_pole_count != `OMT_SENTINEL)
                & (vector_sel | vf_switch_input);
   wire mode_ok = (tuning_mode_and_status == `OMT_MODE_ALL)
                | (tuning_mode_and_status == `OMT_MODE_R1);
   wire [31:0] limit = mode_was_all ? CYC_ALL : CYC_R1;
   wire forced_end = stop_key | (start_was_terminal & ~start_held);
   wire ack = stop_key | (start_was_terminal & ~start_held);
   wire mode_wr = wr & (paddr == `OMT_REG_CONFIG);
   // Eighths of the run elapsed; tick stays below limit while tuning, so it fits 3 bits.
   wire [34:0] progress = {tick, 3'b000} / {3'b000, limit};

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // Only output stop, reset, start inputs, stop key, trip, power loss and measurement faults are looked at while tuning;
   // the second-function select is simply not an input here, which is safer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                  <= ST_IDLE;
         tuning_mode_and_status <= `OMT_MODE_NONE;
         tick                   <= 32'h00000000;
         mode_was_all           <= 1'b0;
         start_was_terminal     <= 1'b0;
         data_valid             <= 1'b0;
         power_err              <= 1'b0;
         drive_reset_done       <= 1'b1;
      end else begin
         case (state)
            ST_IDLE: begin
               tick <= 32'h00000000;
               if (mode_wr) begin
                  tuning_mode_and_status <= pwdata[7:0];
               end
               if (start_edge & allowed & mode_ok & drive_reset_done & ~power_loss) begin
                  state              <= ST_TUNE;
                  mode_was_all       <= (tuning_mode_and_status == `OMT_MODE_ALL);
                  start_was_terminal <= forward_start_input | reverse_start_input;
                  tuning_mode_and_status <= (tuning_mode_and_status == `OMT_MODE_ALL) ?
                                            `OMT_ST_RUN_ALL : `OMT_ST_RUN_R1;
               end
            end
            ST_TUNE: begin
               tick <= tick + 32'h00000001;
               // Priority: reset-type inputs and forced ends, then trips or power loss, then stall, DC bus, calculation faults.
               if (output_stop_input | reset_input | forced_end) begin
                  state <= ST_ERR;
                  tuning_mode_and_status <= `OMT_ERR_FORCED;
               end else if (prot_trip | power_loss) begin
                  state <= ST_ERR;
                  tuning_mode_and_status <= `OMT_ERR_TRIP;
                  power_err <= power_loss;
               end else if (meas_stall) begin
                  state <= ST_ERR;
                  tuning_mode_and_status <= `OMT_ERR_STALL;
               end else if (meas_dcbus) begin
                  state <= ST_ERR;
                  tuning_mode_and_status <= `OMT_ERR_DCBUS;
               end else if (meas_calc_err) begin
                  state <= ST_ERR;
                  tuning_mode_and_status <= `OMT_ERR_CALC;
               end else if (tick + 32'h00000001 >= limit) begin
                  state      <= ST_DONE;
                  data_valid <= 1'b1;
                  tuning_mode_and_status <= mode_was_all ?
                                            `OMT_ST_DONE_ALL : `OMT_ST_DONE_R1;
               end
            end
            ST_DONE: begin
               // Status stays at completion until acknowledged or a new mode is written.
               if (ack) begin
                  state <= ST_IDLE;
                  tuning_mode_and_status <= mode_was_all ? `OMT_MODE_ALL : `OMT_MODE_R1;
               end
               if (mode_wr) begin
                  data_valid <= 1'b0;
                  tuning_mode_and_status <= pwdata[7:0];
                  state <= ST_IDLE;
               end
            end
            ST_ERR: begin
               drive_reset_done <= 1'b0;
               // A supply error clears itself once power is back, so a held start
               // can run the motor normally.
               if (ack | reset_input | (power_err & ~power_loss)) begin
                  state     <= ST_IDLE;
                  power_err <= 1'b0;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // A drive reset, by pin or control bit, re-arms tuning after an error.
         if (reset_input | (wr & (paddr == `OMT_REG_CTRL) & pwdata[`OMT_CTRL_DR_RESET])) begin
            drive_reset_done <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Constant store
   // ****************************************************************
   // Each constant slot takes the engine result plus its index only at a normal end; mode 11 writes slot 0 only.
   genvar gi;
   generate
      for (gi = 0; gi < `OMT_NUM_CONST; gi = gi + 1) begin : g_const
         localparam [15:0] SLOT = gi;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               consts[gi] <= `OMT_SENTINEL;
            end else if (state == ST_TUNE && tick + 32'h00000001 >= limit
                         && !(output_stop_input | reset_input | forced_end | prot_trip
                              | power_loss | meas_stall | meas_dcbus | meas_calc_err)
                         && (mode_was_all || gi == 0)) begin
               consts[gi] <= meas_in + SLOT;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Configuration and edge registers
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_capacity_setting <= `OMT_SENTINEL;
         motor_pole_count       <= `OMT_SENTINEL;
         vector_sel             <= 1'b0;
         monitor_sel_speed      <= 1'b0;
         meas_in                <= 16'h0000;
         set_freq               <= 16'h0000;
         fwd_d                  <= 1'b0;
         rev_d                  <= 1'b0;
         run_d                  <= 1'b0;
      end else begin
         fwd_d <= forward_start_input;
         rev_d <= reverse_start_input;
         run_d <= run_key;
         if (wr && paddr == `OMT_REG_CTRL) begin
            vector_sel        <= pwdata[`OMT_CTRL_VECTOR];
            monitor_sel_speed <= pwdata[2];
         end
         if (wr && paddr == `OMT_REG_STATUS && state != ST_TUNE) begin
            motor_capacity_setting <= pwdata[15:0];
            motor_pole_count       <= pwdata[31:16];
         end
         if (wr && paddr == `OMT_REG_MEAS_IN) begin
            meas_in  <= pwdata[15:0];
            set_freq <= pwdata[31:16];
         end
      end
   end

   // ****************************************************************
   // Outputs and APB read
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_output          <= 1'b0;
         analogue_monitor_output <= 3'h0;
         fault_relay             <= 1'b0;
         normal_run              <= 1'b0;
         tuning_active           <= 1'b0;
         prdata                  <= 32'h00000000;
         pready                  <= 1'b0;
         pslverr                 <= 1'b0;
      end else begin
         running_output <= (state == ST_TUNE) | (state == ST_IDLE & ~power_loss
                           & start_held & ~mode_ok);
         normal_run     <= (state == ST_IDLE) & start_held & ~mode_ok & ~power_loss;
         tuning_active  <= (state == ST_TUNE);
         fault_relay    <= (state == ST_ERR) &
                           (tuning_mode_and_status == `OMT_ERR_TRIP);
         // Progress in eighths of the expected time.
         analogue_monitor_output <= (state == ST_TUNE && monitor_sel_speed) ?
                                    progress[2:0] :
                                    3'h0;
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `OMT_REG_MONITOR | paddr[1:0] != 2'b00);
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `OMT_REG_CTRL:    prdata <= {29'h0, monitor_sel_speed, ~drive_reset_done,
                                            vector_sel};
               `OMT_REG_CONFIG:  prdata <= {22'h0, data_valid, state == ST_TUNE,
                                            tuning_mode_and_status};
               `OMT_REG_STATUS:  prdata <= {motor_pole_count, motor_capacity_setting};
               `OMT_REG_MEAS_IN: prdata <= {set_freq, meas_in};
               `OMT_REG_MONITOR: prdata <= {16'h0, (state == ST_TUNE) ?
                                            16'h0000 : set_freq};
               default: begin
                  if (paddr >= `OMT_REG_CONST0 && paddr < `OMT_REG_CONST0 + 12'h01C) begin
                     prdata <= {16'h0, consts[paddr[4:2] - 3'd4]};
                  end else begin
                     prdata <= 32'h00000000;
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/omt_seq_sva.sv ====
// Port checker for the offline motor tuning sequencer.
// Assumes a bind onto omt_sequencer, one clock pclk and reset presetn.
`timescale 1ns/1ps
`default_nettype none
module omt_seq_sva (
   // Clock and reset.
   input wire logic       pclk,
   input wire logic       presetn,
   // Terminal and event inputs.
   input wire logic       run_key,
   input wire logic       stop_key,
   input wire logic       forward_start_input,
   input wire logic       reverse_start_input,
   input wire logic       output_stop_input,
   input wire logic       reset_input,
   input wire logic       power_loss,
   input wire logic       prot_trip,
   // Outputs under watch.
   input wire logic       running_output,
   input wire logic [2:0] analogue_monitor_output,
   input wire logic       fault_relay,
   input wire logic       normal_run,
   input wire logic       tuning_active
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Any start request; a run can only begin from one of these.
   wire logic go;
   assign go = run_key | forward_start_input | reverse_start_input;
   a_start_cause: assert property (
      $rose(tuning_active) |-> go || $past(go)) else $error("tuning began without a start");
   a_run_on_tune: assert property (
      $rose(tuning_active) |-> ##[0:1] running_output) else $error("running output late");
   a_stop_ends: assert property (
      output_stop_input && tuning_active |-> ##[1:2] !tuning_active) else $error("stop kept run");
   a_key_ends: assert property (
      stop_key && tuning_active |-> ##[1:2] !tuning_active) else $error("stop key kept run");
   a_reset_ends: assert property (
      reset_input && tuning_active |-> ##[1:2] !tuning_active) else $error("reset kept run");
   a_power_ends: assert property (
      power_loss && tuning_active |-> ##[1:2] !tuning_active) else $error("power loss ignored");
   a_trip_relay: assert property (
      prot_trip && tuning_active |-> ##[1:2] fault_relay) else $error("trip gave no relay");
   a_relay_idle: assert property (
      fault_relay |-> !tuning_active) else $error("relay while tuning");
   a_mon_steps: assert property (
      tuning_active && $past(tuning_active) |-> analogue_monitor_output >=
      $past(analogue_monitor_output)) else $error("progress went back");
   a_no_normal: assert property (
      tuning_active |-> !normal_run) else $error("normal run while tuning");
endmodule
bind omt_sequencer omt_seq_sva u_sva (.*);
`default_nettype wire

// ==== tb/omt_panel.sv ====
// Operator panel and terminal model that faces the sequencer.
// Assumes the bench asks for key levels on want, bit order as keys.
`timescale 1ns/1ps
`default_nettype none
module omt_panel (
   // Clock and reset.
   input wire logic       pclk,
   input wire logic       presetn,
   // Requests and supply state.
   input wire logic [6:0] want,
   input wire logic       power_loss,
   // Keys: run, stop, forward, reverse, output stop, reset, vf switch.
   output logic     [6:0] keys
);
   // ****************************************************************
   // Key register
   // ****************************************************************
   // Keys move only after an edge; a forward or reverse start input may rise only with power up.
   // The second function select is never toggled, and the applied motor
   // code is taken as already set to a tuning code.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keys <= 7'h00;
      end else begin
         keys <= want;
         if (power_loss) begin
            keys[3:2] <= want[3:2] & keys[3:2];
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/tb_offline_motor_tuning_sequencer.sv ====
// Self-checking bench for the offline motor tuning sequencer.
// Assumes shortened tuning counts and the panel model on the keys.
`timescale 1ns/1ps
`include "omt_defines.vh"
`default_nettype none
module tb_offline_motor_tuning_sequencer;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [6:0]  want = 7'h00;
   logic        power_loss = 0;
   logic [3:0]  ev = 4'h0;
   logic [31:0] r;
   logic        err;
   wire  [31:0] prdata;
   wire  [6:0]  keys;
   wire  [2:0]  mon;
   wire         pready, pslverr, run_o, relay, normal_run, tuning;
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;
   // ****************************************************************
   // Clock, timeout and instances
   // ****************************************************************
   always #4 pclk = ~pclk;
   // Cut a hang short well above the expected run length.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         close_out();
      end
   end
   omt_panel pnl (.pclk(pclk), .presetn(presetn), .want(want), .power_loss(power_loss),
      .keys(keys));
   omt_sequencer #(.CYC_ALL(32'd64), .CYC_R1(32'd16)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_key(keys[0]),
      .stop_key(keys[1]), .forward_start_input(keys[2]), .reverse_start_input(keys[3]),
      .output_stop_input(keys[4]), .reset_input(keys[5]), .vf_switch_input(keys[6]),
      .power_loss(power_loss), .meas_stall(ev[0]), .meas_dcbus(ev[1]),
      .meas_calc_err(ev[2]), .prot_trip(ev[3]), .running_output(run_o),
      .analogue_monitor_output(mon), .fault_relay(relay), .normal_run(normal_run),
      .tuning_active(tuning));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic cy(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic key(input int b, input logic v);
      @(posedge pclk);
      want[b] <= v;
   endtask
   task automatic drst;
      key(5, 1);
      cy(2);
      key(5, 0);
      cy(4);
   endtask
   task automatic prep(input logic [7:0] m, input logic [2:0] c, input logic [15:0] cap);
      apb(1, `OMT_REG_CTRL, {29'h0, c});
      apb(1, `OMT_REG_STATUS, {16'h0004, cap});
      apb(1, `OMT_REG_CONFIG, {24'h0, m});
   endtask
   // Poll the status field, bounded, and compare it once.
   task automatic waitst(input logic [7:0] c);
      int n;
      n = 0;
      apb(0, `OMT_REG_CONFIG, 32'h0);
      while (r[7:0] !== c && n < 80) begin
         apb(0, `OMT_REG_CONFIG, 32'h0);
         n++;
      end
      chk("status", {24'h0, c}, {24'h0, r[7:0]});
   endtask
   task automatic close_out;
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Idle state, unmapped offset and refused starts.
   task automatic t_idle;
      logic [2:0] c[3] = '{3'h1, 3'h1, 3'h0};
      logic [15:0] k[3] = '{16'h0015, `OMT_SENTINEL, 16'h0015};
      apb(0, `OMT_REG_CONFIG, 32'h0);
      chk("config", 32'h0, r);
      apb(0, 12'h034, 32'h0);
      chk("slverr", 1, err);
      for (int i = 0; i < 3; i++) begin
         prep(i == 0 ? 8'h00 : 8'h01, c[i], k[i]);
         key(2, 1);
         cy(8);
         chk("refused", 0, tuning);
         key(2, 0);
         cy(6);
      end
   endtask
   // Full run with progress shown, held completion and release.
   task automatic t_all;
      int n;
      n = 0;
      apb(1, `OMT_REG_MEAS_IN, 32'h0032_0045);
      prep(8'h01, 3'h5, 16'h0015);
      key(2, 1);
      cy(4);
      chk("running", 1, run_o);
      waitst(8'h02);
      apb(0, `OMT_REG_MONITOR, 32'h0);
      chk("setfreq", 0, r);
      while (mon !== 3'h4 && n < 80) begin
         cy(1);
         n++;
      end
      chk("progress", 3'h4, mon);
      waitst(8'h03);
      cy(20);
      apb(0, `OMT_REG_CONFIG, 32'h0);
      chk("done", {1'b1, 8'h03}, {r[9], r[7:0]});
      apb(0, `OMT_REG_CONST0, 32'h0);
      chk("const0", 32'h0000_0045, r);
      apb(0, 12'h028, 32'h0);
      chk("const6", 32'h0000_004B, r);
      key(2, 0);
      waitst(8'h01);
   endtask
   // Resistance-only run under the vf switch, then a mode change.
   task automatic t_r1;
      key(6, 1);
      prep(8'h0B, 3'h0, 16'h0015);
      key(3, 1);
      waitst(8'h0C);
      waitst(8'h0D);
      apb(1, `OMT_REG_CONFIG, 32'h1);
      apb(0, `OMT_REG_CONFIG, 32'h0);
      chk("valid", 0, r[9]);
      key(3, 0);
      key(6, 0);
      cy(8);
   endtask
   // Forced ends need a drive reset before a new start is taken.
   task automatic t_abort;
      prep(8'h01, 3'h1, 16'h0015);
      key(2, 1);
      waitst(8'h02);
      key(2, 0);
      waitst(8'h08);
      key(2, 1);
      cy(8);
      chk("blocked", 0, tuning);
      key(2, 0);
      drst();
      apb(1, `OMT_REG_CONFIG, 32'h1);
      key(2, 1);
      waitst(8'h02);
      key(1, 1);
      waitst(8'h08);
      key(1, 0);
      key(2, 0);
      drst();
   endtask
   // Each measurement fault gives its own code.
   task automatic t_errs;
      logic [7:0] code[4] = '{`OMT_ERR_STALL, `OMT_ERR_DCBUS, `OMT_ERR_CALC, `OMT_ERR_TRIP};
      for (int i = 0; i < 4; i++) begin
         apb(1, `OMT_REG_CONFIG, 32'h1);
         key(2, 1);
         waitst(8'h02);
         ev <= 4'h1 << i;
         waitst(code[i]);
         if (i == 3) chk("relay", 1, relay);
         ev <= 4'h0;
         key(2, 0);
         drst();
      end
   endtask
   // Output stop, reset input and power loss each end a run.
   task automatic t_force;
      for (int j = 0; j < 3; j++) begin
         apb(1, `OMT_REG_CONFIG, 32'h1);
         key(2, 1);
         waitst(8'h02);
         if (j < 2) key(4 + j, 1);
         else power_loss <= 1;
         cy(4);
         chk("ended", 0, tuning);
         if (j < 2) key(4 + j, 0);
         power_loss <= 0;
         cy(6);
         if (j == 2) chk("normal", 1, normal_run);
         key(2, 0);
         drst();
      end
   endtask
   initial begin
      cy(8);
      presetn <= 1;
      cy(1);
      t_idle();
      t_all();
      t_r1();
      t_abort();
      t_errs();
      t_force();
      close_out();
   end
endmodule
`default_nettype wire
